// ===== core/iaps_defs.vh
// Functional notes
// - pixel store writes only pixels whose mask bit is one, bit 0 lowest
// - pixel width comes from the status pixel-size field
// - only mask bits for pixels fitting 64 bits are consulted
// - after a pixel store the mask shifts right by 8/bytes per pixel
// - autoincrement writes offset plus base back to the base register
// - a misaligned pixel store traps instead of completing
// - an all-zero mask still issues the store with no byte enables
// - unsigned add: sum, overflow and condition both take bit 31 carry
// - signed add: overflow is carry31 xor carry30, condition when negative
// - unsigned subtract: overflow is not carry31, condition is carry31
// - signed subtract: overflow from carries, condition when src2 > src1
// - an immediate first source is sign-extended, unsigned forms too
// - writing register zero changes no register; flags and status still update
// - logical right shift saves its count in the status shift field
// - arithmetic right shift replicates the sign bit
// - shift counts use only the low five bits
// - double shift: src1 high, src2 low, right by saved count, low word
// - shifts never touch the condition flag or the floating-point registers
// - double shift dual-mode bit is taken as for floating point
`ifndef IAPS_DEFS_VH
`define IAPS_DEFS_VH
`define IAPS_ADR_CMD 6'h00
`define IAPS_ADR_SRC1 6'h04
`define IAPS_ADR_SRC2 6'h08
`define IAPS_ADR_IMM 6'h0C
`define IAPS_ADR_PSR 6'h10
`define IAPS_ADR_RES 6'h14
`define IAPS_ADR_FPLO 6'h18
`define IAPS_ADR_FPHI 6'h1C
`define IAPS_ADR_STAT 6'h20
`define IAPS_OP_ADDU 4'h1
`define IAPS_OP_ADDS 4'h2
`define IAPS_OP_SUBU 4'h3
`define IAPS_OP_SUBS 4'h4
`define IAPS_OP_SHL 4'h5
`define IAPS_OP_SHR 4'h6
`define IAPS_OP_SHRA 4'h7
`define IAPS_OP_SHRD 4'h8
`define IAPS_OP_PST 4'h9
`define IAPS_CMD_OP 3:0
`define IAPS_CMD_IMM 4
`define IAPS_CMD_DST 9:5
`define IAPS_CMD_AUTO 10
`define IAPS_CMD_DUAL 11
`define IAPS_PSR_CC 0
`define IAPS_PSR_OF 1
`define IAPS_PSR_SC 6:2
`define IAPS_PSR_PS 9:8
`define IAPS_PSR_PM 23:16
`define IAPS_PSR_DUAL 24
`define IAPS_PS_8 2'h0
`define IAPS_PS_16 2'h1
`define IAPS_PSR_RST 32'h0000_0000
`define IAPS_ZERO_REG 5'h00
`define IAPS_ALIGN 2:0
`endif

// ===== core/iaps_alu.v
// The register addresses and register access over Wishbone were decided locally.
`timescale 1ns/10ps
`include "iaps_defs.vh"
module iaps_alu (
  input wire sys_clk_in,
  input wire nrst_in,
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_we_in,
  input wire [5:0] wb_adr_in,
  input wire [3:0] wb_sel_in,
  input wire [31:0] wb_dat_in,
  output reg [31:0] wb_dat_out,
  output reg wb_ack_out,
  output reg rf_we_out,
  output reg [4:0] rf_waddr_out,
  output reg [31:0] rf_wdata_out,
  output reg mem_req_out,
  output reg [31:0] mem_addr_out,
  output reg [63:0] mem_data_out,
  output reg [7:0] mem_be_out,
  output reg trap_out
);
  // software-loaded operands
  reg [31:0] src1_q;
  reg [31:0] src2_q;
  reg [15:0] imm_q;
  reg [31:0] fplo_q;
  reg [31:0] fphi_q;
  // last result, readable by software
  reg [31:0] res_q;

  // status word fields
  reg cc_q;
  reg of_q;
  reg [4:0] sc_q;
  reg [1:0] ps_q;
  reg [7:0] pm_q;
  reg dual_q;
  reg trap_q;

  // status fields reset from one word so the reset map lives in one place
  localparam [31:0] psr_rst = `IAPS_PSR_RST;

  // a request is answered one edge after it appears; writes land on the next edge, while ack is high
  wire acc = wb_cyc_in & wb_stb_in & wb_ack_out;
  wire wr = acc & wb_we_in;
  // a command needs both low lanes: a half write could not carry op and dst
  wire go = wr & (wb_adr_in == `IAPS_ADR_CMD) & wb_sel_in[0] & wb_sel_in[1];
  wire psr_wr = wr & (wb_adr_in == `IAPS_ADR_PSR);
  wire stat_wr = wr & (wb_adr_in == `IAPS_ADR_STAT);

  wire [3:0] op = wb_dat_in[`IAPS_CMD_OP];
  wire use_imm = wb_dat_in[`IAPS_CMD_IMM];
  wire [4:0] dst = wb_dat_in[`IAPS_CMD_DST];
  wire auto = wb_dat_in[`IAPS_CMD_AUTO];
  wire dual = wb_dat_in[`IAPS_CMD_DUAL];

  // one decode per special op keeps the execute block readable
  wire is_shr = (op == `IAPS_OP_SHR);
  wire is_shrd = (op == `IAPS_OP_SHRD);

  // the immediate is sign-extended for the unsigned forms as well
  wire [31:0] imm_sx = {{16{imm_q[15]}}, imm_q};
  wire [31:0] a = use_imm ? imm_sx : src1_q;
  wire [31:0] b = src2_q;
  // only the low five count bits are used, so counts wrap at 32
  wire [4:0] cnt = src1_q[4:0];

  // subtract adds the inverted second source with a carry in
  wire is_sub = (op == `IAPS_OP_SUBU) | (op == `IAPS_OP_SUBS);
  wire [31:0] bx = is_sub ? ~b : b;
  wire cin = is_sub;
  wire [32:0] sum = {1'b0, a} + {1'b0, bx} + {32'h0000_0000, cin};
  // carry into bit 31 comes from a separate add of the low 31 bits
  wire [31:0] lo31 = {1'b0, a[30:0]} + {1'b0, bx[30:0]} +
                     {31'h0000_0000, cin};
  wire c31 = sum[32];
  wire c30 = lo31[31];
  wire sov = c31 ^ c30;
  // the true sign survives overflow, so compares hold at the extremes
  wire sneg = sum[31] ^ sov;

  // the double shift uses the count saved by the last logical right shift
  wire [63:0] dbl = {src1_q, src2_q} >> sc_q;
  wire [31:0] sra = $signed(b) >>> cnt;

  // pixel store address and byte enables
  wire [31:0] ea = imm_sx + src2_q;
  // the store always moves a doubleword, so alignment is on 8 bytes
  wire misal = |ea[`IAPS_ALIGN];
  wire [7:0] be;
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_be
      wire pm8 = pm_q[i];
      wire pm16 = pm_q[i / 2];
      wire pm32 = pm_q[i / 4];
      // byte i belongs to pixel i>>ps, or i>>2 when ps is 3; higher mask bits never reached
      assign be[i] = (ps_q == `IAPS_PS_8) ? pm8 :
                     (ps_q == `IAPS_PS_16) ? pm16 :
                     pm32;
    end
  endgenerate

  // the mask moves on by the number of pixels one doubleword holds
  reg [7:0] pm_next;
  always @* begin
    case (ps_q)
      `IAPS_PS_8: pm_next = 8'h00; // all eight bits used up
      `IAPS_PS_16: pm_next = {4'h0, pm_q[7:4]};
      default: pm_next = {2'h0, pm_q[7:2]};
    endcase
  end

  reg [31:0] res;
  reg wres;
  reg upd_flags;
  reg nc;
  reg no;
  always @* begin
    res = 32'h0000_0000;
    wres = 1'b1;
    upd_flags = 1'b0;
    nc = cc_q;
    no = of_q;
    case (op)
      `IAPS_OP_ADDU: begin
        res = sum[31:0];
        upd_flags = 1'b1;
        nc = c31;
        no = c31;
      end
      `IAPS_OP_ADDS: begin
        res = sum[31:0];
        upd_flags = 1'b1;
        nc = sneg;
        no = sov;
      end
      `IAPS_OP_SUBU: begin
        res = sum[31:0];
        upd_flags = 1'b1;
        nc = c31;
        no = ~c31;
      end
      `IAPS_OP_SUBS: begin
        res = sum[31:0];
        upd_flags = 1'b1;
        nc = sneg;
        no = sov;
      end
      // shifts leave upd_flags low, so both flags keep their value
      `IAPS_OP_SHL: begin
        res = b << cnt;
        upd_flags = 1'b0;
      end
      `IAPS_OP_SHR: begin
        res = b >> cnt;
        upd_flags = 1'b0;
      end
      `IAPS_OP_SHRA: begin
        res = sra;
        upd_flags = 1'b0;
      end
      `IAPS_OP_SHRD: begin
        res = dbl[31:0];
        upd_flags = 1'b0;
      end
      `IAPS_OP_PST: begin
        res = ea;
        // a trapping store must not touch the base register
        wres = auto & ~misal;
      end
      default: begin
        // unknown op codes write no register, but still clear the result register
        wres = 1'b0;
      end
    endcase
  end

  wire is_pst = (op == `IAPS_OP_PST);

  // execute
  always @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      res_q <= 32'h0000_0000;
      cc_q <= psr_rst[`IAPS_PSR_CC];
      of_q <= psr_rst[`IAPS_PSR_OF];
      sc_q <= psr_rst[`IAPS_PSR_SC];
      ps_q <= psr_rst[`IAPS_PSR_PS];
      pm_q <= psr_rst[`IAPS_PSR_PM];
      dual_q <= psr_rst[`IAPS_PSR_DUAL];
      rf_we_out <= 1'b0;
      rf_waddr_out <= 5'h00;
      rf_wdata_out <= 32'h0000_0000;
      mem_req_out <= 1'b0;
      mem_addr_out <= 32'h0000_0000;
      mem_data_out <= 64'h0000_0000_0000_0000;
      mem_be_out <= 8'h00;
      trap_out <= 1'b0;
    end else begin
      rf_we_out <= 1'b0;
      mem_req_out <= 1'b0;
      trap_out <= 1'b0;
      if (go) begin
        // everything settles at this one edge
        res_q <= res;
        rf_waddr_out <= dst;
        rf_wdata_out <= res;
        rf_we_out <= wres & (dst != `IAPS_ZERO_REG);
        if (upd_flags) begin
          cc_q <= nc; // shifts leave it alone
          of_q <= no;
        end
        if (is_shr)
          sc_q <= cnt;
        if (is_shrd)
          dual_q <= dual;
        if (is_pst) begin
          trap_out <= misal;
          // mask and bus cycle only move when the store really goes out
          if (!misal) begin
            // bus cycle goes out even with an empty mask
            mem_req_out <= 1'b1;
            mem_addr_out <= ea;
            mem_data_out <= {fphi_q, fplo_q};
            mem_be_out <= be;
            pm_q <= pm_next;
          end
        end
      end else if (psr_wr) begin
        // a command is listed first, so it wins over a status write
        if (wb_sel_in[0]) begin
          cc_q <= wb_dat_in[`IAPS_PSR_CC];
          of_q <= wb_dat_in[`IAPS_PSR_OF];
        end
        // the count lies in lane 0 only, but is written only when lanes 0 and 1 are both selected
        if (wb_sel_in[0] && wb_sel_in[1])
          sc_q <= wb_dat_in[`IAPS_PSR_SC];
        if (wb_sel_in[1])
          ps_q <= wb_dat_in[`IAPS_PSR_PS];
        if (wb_sel_in[2])
          pm_q <= wb_dat_in[`IAPS_PSR_PM];
      end
    end
  end

  // sticky trap: set by a trapping store, cleared by writing one; the set
  // wins when both fall on one edge so no trap is ever lost
  always @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      trap_q <= 1'b0;
    end else if (go && is_pst && misal) begin
      trap_q <= 1'b1;
    end else if (stat_wr && wb_sel_in[0] && wb_dat_in[0]) begin
      trap_q <= 1'b0;
    end
  end

  // operand registers, byte-lane writable
  // operands keep their value across commands so software may reuse them
  function [31:0] lanes;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    begin
      lanes = {sel[3] ? nw[31:24] : old[31:24],
               sel[2] ? nw[23:16] : old[23:16],
               sel[1] ? nw[15:8] : old[15:8],
               sel[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  always @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      src1_q <= 32'h0000_0000;
      src2_q <= 32'h0000_0000;
      imm_q <= 16'h0000;
      fplo_q <= 32'h0000_0000;
      fphi_q <= 32'h0000_0000;
    end else if (wr) begin
      case (wb_adr_in)
        `IAPS_ADR_SRC1: src1_q <= lanes(src1_q, wb_dat_in, wb_sel_in);
        `IAPS_ADR_SRC2: src2_q <= lanes(src2_q, wb_dat_in, wb_sel_in);
        `IAPS_ADR_IMM: begin
          // only the low half exists; it is sign-extended where used
          if (wb_sel_in[0])
            imm_q[7:0] <= wb_dat_in[7:0];
          if (wb_sel_in[1])
            imm_q[15:8] <= wb_dat_in[15:8];
        end
        `IAPS_ADR_FPLO: fplo_q <= lanes(fplo_q, wb_dat_in, wb_sel_in);
        `IAPS_ADR_FPHI: fphi_q <= lanes(fphi_q, wb_dat_in, wb_sel_in);
        default: ;
      endcase
    end
  end

  // status word as seen by software
  wire [31:0] psr_rd;
  assign psr_rd[`IAPS_PSR_CC] = cc_q;
  assign psr_rd[`IAPS_PSR_OF] = of_q;
  assign psr_rd[`IAPS_PSR_SC] = sc_q;
  // reserved bits read as zero
  assign psr_rd[7] = 1'b0;
  assign psr_rd[`IAPS_PSR_PS] = ps_q;
  assign psr_rd[15:10] = 6'h00;
  assign psr_rd[`IAPS_PSR_PM] = pm_q;
  assign psr_rd[`IAPS_PSR_DUAL] = dual_q;
  assign psr_rd[31:25] = 7'h00;

  // unmapped offsets and the command word read back as zero
  reg [31:0] rd;
  always @* begin
    case (wb_adr_in)
      `IAPS_ADR_SRC1: rd = src1_q;
      `IAPS_ADR_SRC2: rd = src2_q;
      `IAPS_ADR_IMM: rd = {16'h0000, imm_q};
      `IAPS_ADR_PSR: rd = psr_rd;
      `IAPS_ADR_RES: rd = res_q;
      `IAPS_ADR_FPLO: rd = fplo_q;
      `IAPS_ADR_FPHI: rd = fphi_q;
      `IAPS_ADR_STAT: rd = {31'h0000_0000, trap_q};
      default: rd = 32'h0000_0000;
    endcase
  end

  // one wait state keeps read data and ack both straight from flops
  always @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      // no ack in the cycle after an ack, so each request gets exactly one
      wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
      // refreshed every cycle; the master takes it at the ack edge
      wb_dat_out <= rd;
    end
  end
endmodule // iaps_alu

// ===== verif/iaps_alu_asserts.sv
`timescale 1ns/10ps
module iaps_alu_chk (
  input wire sys_clk_in,
  input wire nrst_in,
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_we_in,
  input wire [5:0] wb_adr_in,
  input wire [31:0] wb_dat_in,
  input wire wb_ack_out,
  input wire rf_we_out,
  input wire [4:0] rf_waddr_out,
  input wire mem_req_out,
  input wire [31:0] mem_addr_out,
  input wire trap_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_cmd;
    wb_ack_out && wb_we_in && wb_adr_in == 6'h00;
  endsequence
  property p_ack_pulse;
    wb_ack_out |=> !wb_ack_out;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_ack_req;
    wb_ack_out |-> $past(wb_cyc_in && wb_stb_in);
  endproperty
  a_ack_req: assert property (p_ack_req)
    else $error("ack without request");
  property p_quiet;
    !wb_ack_out |=> !rf_we_out && !mem_req_out && !trap_out;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("result pulse without command");
  property p_zero_dst;
    s_cmd ##0 (wb_dat_in[9:5] == 5'h00) |=> !rf_we_out;
  endproperty
  a_zero_dst: assert property (p_zero_dst)
    else $error("write to zero register");
  property p_arith_one;
    s_cmd ##0 (wb_dat_in[3:0] != 4'h0 && wb_dat_in[3:0] < 4'h9 &&
      wb_dat_in[9:5] != 5'h00) |=>
      rf_we_out && rf_waddr_out == $past(wb_dat_in[9:5]);
  endproperty
  a_arith_one: assert property (p_arith_one)
    else $error("result not in one cycle");
  property p_pst_issue;
    s_cmd ##0 (wb_dat_in[3:0] == 4'h9) |=> mem_req_out != trap_out;
  endproperty
  a_pst_issue: assert property (p_pst_issue)
    else $error("store neither issued nor trapped");
  property p_aligned;
    mem_req_out |-> mem_addr_out[2:0] == 3'h0;
  endproperty
  a_aligned: assert property (p_aligned)
    else $error("misaligned store issued");
  property p_trap_cause;
    trap_out |-> !mem_req_out &&
      $past(wb_ack_out && wb_adr_in == 6'h00 && wb_dat_in[3:0] == 4'h9);
  endproperty
  a_trap_cause: assert property (p_trap_cause)
    else $error("trap without pixel store");
endmodule // iaps_alu_chk
bind iaps_alu iaps_alu_chk iaps_alu_chk_inst (.sys_clk_in, .nrst_in,
  .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_in, .wb_ack_out,
  .rf_we_out, .rf_waddr_out, .mem_req_out, .mem_addr_out, .trap_out);

// ===== verif/iaps_mem_model.sv
`timescale 1ns/10ps
module iaps_mem_model (
  input wire clk_in,
  input wire req_in,
  input wire [7:0] be_in,
  input wire [63:0] data_in,
  output reg [63:0] dword_out
);
  integer i;
  initial dword_out = 64'h0000_0000_0000_0000;
  always @(posedge clk_in)
    if (req_in)
      for (i = 0; i < 8; i = i + 1)
        if (be_in[i])
          dword_out[8 * i +: 8] <= data_in[8 * i +: 8];
endmodule // iaps_mem_model

// ===== verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  reg sys_clk_in = 0;
  reg nrst_in = 0;
  reg wb_cyc_in = 0;
  reg wb_stb_in = 0;
  reg wb_we_in = 0;
  reg [5:0] wb_adr_in = 6'h00;
  reg [3:0] wb_sel_in = 4'h0;
  reg [31:0] wb_dat_in = 32'h0000_0000;
  wire [31:0] wb_dat_out, rf_wdata_out, mem_addr_out;
  wire [63:0] mem_data_out, dword;
  wire [7:0] mem_be_out;
  wire [4:0] rf_waddr_out;
  wire wb_ack_out, rf_we_out, mem_req_out, trap_out;
  integer bad_count = 0;
  integer checked = 0;
  integer seed = 32'h5da2_410b;
  integer k, i;
  reg [31:0] s1, s2, r, q;
  reg [63:0] mexp, w;
  reg [32:0] t;
  reg [15:0] imm;
  reg [7:0] pm, bex;
  reg [4:0] sc, dst;
  reg [3:0] op;
  reg [1:0] ps;
  reg cc, of, c30, dual, ui, stky;
  iaps_alu iaps_alu_inst (.sys_clk_in, .nrst_in, .wb_cyc_in, .wb_stb_in,
    .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
    .rf_we_out, .rf_waddr_out, .rf_wdata_out, .mem_req_out, .mem_addr_out,
    .mem_data_out, .mem_be_out, .trap_out);
  iaps_mem_model iaps_mem_model_inst (.clk_in(sys_clk_in),
    .req_in(mem_req_out), .be_in(mem_be_out), .data_in(mem_data_out),
    .dword_out(dword));
  initial forever #4 sys_clk_in = ~sys_clk_in;
  task chk(input [63:0] seen, input [63:0] exp, input [63:0] nm);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task wb(input [5:0] ad, input [31:0] d, input wr);
    begin
      @(posedge sys_clk_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= wr;
      wb_adr_in <= ad;
      wb_sel_in <= 4'hf;
      wb_dat_in <= d;
      @(posedge sys_clk_in);
      while (wb_ack_out !== 1'b1)
        @(posedge sys_clk_in);
      q = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
    end
  endtask
  // results land at the ack edge; look half a cycle later, mid-cycle
  task cmd(input [31:0] c);
    begin
      wb(6'h00, c, 1'b1);
      @(negedge sys_clk_in);
    end
  endtask
  task psrchk;
    begin
      wb(6'h10, 0, 1'b0);
      chk(q, {7'h00, dual, pm, 6'h00, ps, 1'b0, sc, of, cc}, "psr");
    end
  endtask
  initial begin
    #200000;
    bad_count = bad_count + 1;
    end_of_test;
  end
  initial begin
    {cc, of, dual, sc, ps, pm, mexp, stky} = 0;
    repeat (6) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    for (k = 0; k < 24; k = k + 1) begin
      op = 4'h1 + k % 4;
      ui = k[2];
      dst = (k < 4) ? 5'h00 : 5'h01 + {$random(seed)} % 31;
      s1 = $random(seed);
      s2 = $random(seed);
      imm = $random(seed);
      wb(6'h04, s1, 1'b1);
      wb(6'h08, s2, 1'b1);
      wb(6'h0c, {16'h0000, imm}, 1'b1);
      if (ui)
        s1 = {{16{imm[15]}}, imm};
      w = (op > 2) ? ~s2 : s2;
      t = {1'b0, s1} + w[31:0] + (op > 2);
      c30 = ((s1 & 32'h7fff_ffff) + (w[31:0] & 32'h7fff_ffff)
        + (op > 2)) >> 31;
      r = t[31:0];
      of = (op == 1) ? t[32] : (op == 3) ? ~t[32] : t[32] ^ c30;
      cc = (op == 1 || op == 3) ? t[32] : r[31] ^ of;
      cmd({20'h0_0000, 2'b00, dst, ui, op});
      chk(rf_we_out, dst != 0, "rf_we");
      chk(rf_waddr_out, dst, "waddr");
      if (dst != 0)
        chk(rf_wdata_out, r, "sum");
      psrchk;
    end
    for (k = 0; k < 12; k = k + 1) begin
      op = 4'h5 + k % 4;
      s1 = $random(seed);
      s2 = $random(seed);
      ui = $random(seed);
      wb(6'h04, s1, 1'b1);
      wb(6'h08, s2, 1'b1);
      w = {s1, s2} >> sc;
      r = w[31:0];
      if (op == 5)
        r = s2 << s1[4:0];
      if (op == 6)
        r = s2 >> s1[4:0];
      if (op == 7)
        r = $signed(s2) >>> s1[4:0];
      if (op == 6)
        sc = s1[4:0];
      if (op == 8)
        dual = ui;
      cmd({20'h0_0000, ui, 1'b0, 5'h01 + k[3:0], 1'b0, op});
      chk(rf_wdata_out, r, "shift");
      chk(rf_waddr_out, 5'h01 + k[3:0], "waddr");
      wb(6'h14, 0, 1'b0);
      chk(q, r, "result");
      psrchk;
    end
    w = {$random(seed), $random(seed)};
    wb(6'h18, w[31:0], 1'b1);
    wb(6'h1c, w[63:32], 1'b1);
    for (k = 0; k < 12; k = k + 1) begin
      ps = k % 4;
      pm = (k == 8) ? 8'h00 : $random(seed);
      s2 = $random(seed) & 32'hffff_fff8;
      imm = (k % 6 == 5) ? 16'h0004 : $random(seed) & 16'hfff8;
      wb(6'h10, {7'h00, dual, pm, 6'h00, ps, 1'b0, sc, of, cc}, 1'b1);
      wb(6'h08, s2, 1'b1);
      wb(6'h0c, {16'h0000, imm}, 1'b1);
      r = s2 + {{16{imm[15]}}, imm};
      for (i = 0; i < 8; i = i + 1) begin
        bex[i] = (ps == 0) ? pm[i] : (ps == 1) ? pm[i / 2] : pm[i / 4];
        if (bex[i] && r[2:0] == 0)
          mexp[8 * i +: 8] = w[8 * i +: 8];
      end
      cmd({20'h0_0000, 1'b0, k[0], 5'h03, 1'b0, 4'h9});
      chk(trap_out, r[2:0] != 0, "trap");
      chk(mem_req_out, r[2:0] == 0, "mem_req");
      chk(rf_we_out, k[0] && r[2:0] == 0, "rf_we");
      if (r[2:0] == 0) begin
        chk(mem_addr_out, r, "addr");
        chk(mem_be_out, bex, "be");
        chk(mem_data_out, w, "data");
        if (k[0])
          chk(rf_wdata_out, r, "base");
        pm = pm >> ((ps == 0) ? 8 : (ps == 1) ? 4 : 2);
      end
      if (r[2:0] != 0)
        stky = 1'b1;
      wb(6'h20, 0, 1'b0);
      chk(q, stky, "sticky");
      if (stky) begin
        wb(6'h20, 1, 1'b1);
        stky = 1'b0;
      end
      psrchk;
      chk(dword, mexp, "memory");
    end
    end_of_test;
  end
endmodule // testbench
